// file: cmhc_pkg.sv
/*
 * Constants and types for the control message header codec.
 * Assumes a byte stream of UDP payload bytes delivered by surrounding logic.
 */
package cmhc_pkg;
	localparam int          HDR_LEN         = 10;
	localparam int          CODE_LEN        = 2;
	localparam int          MIN_LEN         = HDR_LEN + CODE_LEN;
	localparam int          RESP_LEN        = MIN_LEN + CODE_LEN;
	localparam logic [15:0] DEFAULT_PORT    = 16'h2580;
	localparam logic [7:0]  RESV_VALUE      = 8'h00;
	localparam logic [7:0]  GW_COUNT_VALUE  = 8'h02;
	localparam logic [7:0]  ADDR_MAX        = 8'h7F;
	localparam logic [7:0]  NET_MIN         = 8'h01;
	localparam logic [7:0]  UNIT_CPU        = 8'h00;
	localparam logic [7:0]  UNIT_SPECIAL_LO = 8'h10;
	localparam logic [7:0]  UNIT_SPECIAL_HI = 8'h1F;
	localparam logic [7:0]  UNIT_COMM       = 8'hFE;
	localparam logic [7:0]  INFO_RESP_BIT   = 8'h40;
	localparam logic [15:0] RC_OK           = 16'h0000;
	localparam logic [15:0] RC_ROUTING      = 16'h0500;
	localparam logic [15:0] RC_FORMAT       = 16'h1000;
	localparam int          IDX_INFO  = 0;
	localparam int          IDX_RESV  = 1;
	localparam int          IDX_GWCNT = 2;
	localparam int          IDX_DNET = 3;
	localparam int          IDX_DNOD = 4;
	localparam int          IDX_DUNT = 5;
	localparam int          IDX_SNET = 6;
	localparam int          IDX_SNOD = 7;
	localparam int          IDX_SUNT = 8;
	localparam int          IDX_TAG  = 9;
	localparam int          IDX_CMDH = 10;
	localparam int          IDX_CMDL = 11;

	typedef enum logic [1:0] {CMHC_RX, CMHC_WAIT, CMHC_TX} cmhc_state_t;
endpackage

// file: cmhc_codec.sv
/*
 * Control message header codec: captures a command's header and code,
 * checks the header addresses, then emits the response header, echoed code and result code.
 * Assumes payload bytes arrive with valid/last, and that the command text is
 * handled elsewhere; response text, if any, follows TX_LAST from elsewhere.
 */
module cmhc_codec (
	input  wire logic       REF_CLK,      // 125 MHz clock
	input  wire logic       RST_B,        // Async reset, active low
	input  wire logic [15:0] LISTEN_PORT, // UDP port to accept
	input  wire logic       TABLE_OK,     // Address table set up
	input  wire logic [15:0] RX_PORT,     // Destination port of datagram
	input  wire logic       RX_VALID,     // Payload byte valid
	input  wire logic [7:0] RX_DATA,      // Payload byte
	input  wire logic       RX_LAST,      // Last payload byte
	input  wire logic       TX_READY,     // Downstream accepts byte
	output logic            TX_VALID,     // Response byte valid
	output logic [7:0]      TX_DATA,      // Response byte
	output logic            TX_LAST,      // Last response byte
	output logic            CMD_OK,       // Pulse: command passed checks
	output logic [15:0]     CMD_CODE,     // Captured command code
	output logic            DROP          // Pulse: datagram discarded
);
	typedef struct packed {
		cmhc_pkg::cmhc_state_t st;
		logic [11:0][7:0]      hdr;
		logic [3:0]            cnt;
		logic [7:0]            tx_byte;
		logic                  tx_last;
		logic [15:0]           rcode;
		logic                  ok;
		logic                  drop;
		logic                  port_hit;
	} cmhc_reg_t;

	cmhc_reg_t r_q;
	cmhc_reg_t r_d;

	function automatic logic net_ok(input logic [7:0] v);
		net_ok = (v >= cmhc_pkg::NET_MIN) && (v <= cmhc_pkg::ADDR_MAX);
	endfunction

	function automatic logic node_ok(input logic [7:0] v);
		node_ok = (v <= cmhc_pkg::ADDR_MAX);
	endfunction

	function automatic logic unit_ok(input logic [7:0] v);
		unit_ok = (v == cmhc_pkg::UNIT_CPU) || (v == cmhc_pkg::UNIT_COMM)
			|| ((v >= cmhc_pkg::UNIT_SPECIAL_LO) && (v <= cmhc_pkg::UNIT_SPECIAL_HI));
	endfunction

	// Response byte at position i
	function automatic logic [7:0] resp_byte(input logic [11:0][7:0] h,
		input logic [15:0] rc, input logic [3:0] i);
		case (i)
			4'h0: resp_byte = h[cmhc_pkg::IDX_INFO] | cmhc_pkg::INFO_RESP_BIT;
			4'h1: resp_byte = cmhc_pkg::RESV_VALUE;
			4'h2: resp_byte = cmhc_pkg::GW_COUNT_VALUE;
			4'h3: resp_byte = h[cmhc_pkg::IDX_SNET];
			4'h4: resp_byte = h[cmhc_pkg::IDX_SNOD];
			4'h5: resp_byte = h[cmhc_pkg::IDX_SUNT];
			4'h6: resp_byte = h[cmhc_pkg::IDX_DNET];
			4'h7: resp_byte = h[cmhc_pkg::IDX_DNOD];
			4'h8: resp_byte = h[cmhc_pkg::IDX_DUNT];
			4'h9: resp_byte = h[cmhc_pkg::IDX_TAG];
			4'hA: resp_byte = h[cmhc_pkg::IDX_CMDH];
			4'hB: resp_byte = h[cmhc_pkg::IDX_CMDL];
			4'hC: resp_byte = rc[15:8];
			4'hD: resp_byte = rc[7:0];
			default: resp_byte = 8'h00;
		endcase
	endfunction

	logic hdr_good;
	assign hdr_good = net_ok(r_q.hdr[cmhc_pkg::IDX_DNET]) && node_ok(r_q.hdr[cmhc_pkg::IDX_DNOD])
		&& unit_ok(r_q.hdr[cmhc_pkg::IDX_DUNT]) && net_ok(r_q.hdr[cmhc_pkg::IDX_SNET])
		&& node_ok(r_q.hdr[cmhc_pkg::IDX_SNOD]) && unit_ok(r_q.hdr[cmhc_pkg::IDX_SUNT]);

	always_comb
	begin
		r_d = r_q;
		r_d.ok = 1'b0;
		r_d.drop = 1'b0;
		case (r_q.st)
			cmhc_pkg::CMHC_RX:
			begin
				if (RX_VALID)
				begin
					if (r_q.cnt < 4'(cmhc_pkg::MIN_LEN))
					begin
						r_d.hdr[r_q.cnt] = RX_DATA;
						r_d.cnt = r_q.cnt + 4'h1;
					end
					if (r_q.cnt == 4'h0)
						r_d.port_hit = (RX_PORT == LISTEN_PORT);
					if (RX_LAST)
					begin
						if ((r_q.cnt < 4'(cmhc_pkg::MIN_LEN - 1))
							|| !((r_q.cnt == 4'h0) ? (RX_PORT == LISTEN_PORT) : r_q.port_hit))
						begin
							r_d.drop = 1'b1;
							r_d.cnt = 4'h0;
						end
						else
						begin
							r_d.st = cmhc_pkg::CMHC_WAIT;
						end
					end
				end
			end
			cmhc_pkg::CMHC_WAIT:
			begin
				if (!TABLE_OK)
					r_d.rcode = cmhc_pkg::RC_ROUTING;
				else if (!hdr_good)
					r_d.rcode = cmhc_pkg::RC_FORMAT;
				else
					r_d.rcode = cmhc_pkg::RC_OK;
				r_d.ok = TABLE_OK && hdr_good;
				r_d.cnt = 4'h0;
				r_d.st = cmhc_pkg::CMHC_TX;
				r_d.tx_byte = resp_byte(r_q.hdr, cmhc_pkg::RC_OK, 4'h0);
				r_d.tx_last = 1'b0;
			end
			cmhc_pkg::CMHC_TX:
			begin
				if (TX_READY)
				begin
					if (r_q.tx_last)
					begin
						r_d.st = cmhc_pkg::CMHC_RX;
						r_d.cnt = 4'h0;
					end
					else
					begin
						r_d.cnt = r_q.cnt + 4'h1;
						r_d.tx_byte = resp_byte(r_q.hdr, r_q.rcode, r_q.cnt + 4'h1);
						r_d.tx_last = (r_q.cnt == 4'(cmhc_pkg::RESP_LEN - 2));
					end
				end
			end
			default:
			begin
				r_d.st = cmhc_pkg::CMHC_RX;
				r_d.cnt = 4'h0;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_B)
	begin
		if (!RST_B)
			r_q <= '0;
		else
			r_q <= r_d;
	end

	assign TX_VALID = (r_q.st == cmhc_pkg::CMHC_TX);
	assign TX_DATA  = r_q.tx_byte;
	assign TX_LAST  = r_q.tx_last;
	assign CMD_OK   = r_q.ok;
	assign CMD_CODE = {r_q.hdr[cmhc_pkg::IDX_CMDH], r_q.hdr[cmhc_pkg::IDX_CMDL]};
	assign DROP     = r_q.drop;

	property p_short_drop;
		@(posedge REF_CLK) disable iff (!RST_B)
		(r_q.st == cmhc_pkg::CMHC_RX && RX_VALID && RX_LAST
			&& r_q.cnt < 4'(cmhc_pkg::MIN_LEN - 1))
			|=> DROP && !TX_VALID;
	endproperty
	a_short_drop: assert property (p_short_drop) else $error("short payload not dropped");

	property p_rsv;
		@(posedge REF_CLK) disable iff (!RST_B)
		(TX_VALID && r_q.cnt == 4'(cmhc_pkg::IDX_RESV)) |-> TX_DATA == cmhc_pkg::RESV_VALUE;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved byte not zero");

	property p_gw;
		@(posedge REF_CLK) disable iff (!RST_B)
		(TX_VALID && r_q.cnt == 4'(cmhc_pkg::IDX_GWCNT)) |-> TX_DATA == cmhc_pkg::GW_COUNT_VALUE;
	endproperty
	a_gw: assert property (p_gw) else $error("gateway count not two");

	property p_swap;
		@(posedge REF_CLK) disable iff (!RST_B)
		(TX_VALID && r_q.cnt == 4'h3) |-> TX_DATA == r_q.hdr[6];
	endproperty
	a_swap: assert property (p_swap) else $error("network fields not swapped");

	property p_tag;
		@(posedge REF_CLK) disable iff (!RST_B)
		(TX_VALID && r_q.cnt == 4'h9) |-> TX_DATA == r_q.hdr[9];
	endproperty
	a_tag: assert property (p_tag) else $error("service tag not echoed");

	property p_table;
		@(posedge REF_CLK) disable iff (!RST_B)
		(r_q.st == cmhc_pkg::CMHC_WAIT && !TABLE_OK) |=> !CMD_OK && r_q.rcode == 16'h0500;
	endproperty
	a_table: assert property (p_table) else $error("no error response for bad table");

	property p_len;
		@(posedge REF_CLK) disable iff (!RST_B)
		(TX_VALID && TX_LAST) |-> r_q.cnt == 4'(cmhc_pkg::RESP_LEN - 1);
	endproperty
	a_len: assert property (p_len) else $error("response length wrong");

	property p_dnet;
		@(posedge REF_CLK) disable iff (!RST_B)
		(r_q.st == cmhc_pkg::CMHC_WAIT && TABLE_OK && r_q.hdr[3] == 8'h00) |=> !CMD_OK;
	endproperty
	a_dnet: assert property (p_dnet) else $error("network zero accepted");

	// Offered byte stands until taken
	property p_hold;
		@(posedge REF_CLK) disable iff (!RST_B)
		(TX_VALID && !TX_READY) |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST);
	endproperty
	a_hold: assert property (p_hold) else $error("response byte not held");
endmodule

// file: cmhc_host.sv
/*
 * Host partner: sends command payloads and sinks response bytes.
 * Assumes the bench calls send() and reads resp and cnt.
 */
module cmhc_host (
	input  wire logic        clk,      // Codec clock
	input  wire logic        rst_b,    // Async reset, active low
	input  wire logic        stall,    // Toggle ready while high
	input  wire logic        tx_valid, // Response byte valid
	input  wire logic [7:0]  tx_data,  // Response byte
	input  wire logic        tx_last,  // Last response byte
	output logic             tx_ready, // Sink takes byte
	output logic [15:0]      rx_port,  // Datagram port
	output logic             rx_valid, // Payload byte valid
	output logic [7:0]       rx_data,  // Payload byte
	output logic             rx_last   // Last payload byte
);
	logic [7:0] resp [14];
	int         cnt;
	int         last_at;
	initial
	begin
		rx_port = 16'h0000;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_last = 1'b0;
	end
	task automatic send(input logic [127:0] m, input int n, input logic [15:0] p);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			rx_port <= p;
			rx_valid <= 1'b1;
			rx_data <= m[127-8*i -: 8];
			rx_last <= (i == n - 1);
		end
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
		rx_data <= ~rx_data;
		rx_port <= ~p;
	endtask
	always @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			cnt <= 0;
			last_at <= -1;
			tx_ready <= 1'b0;
		end
		else
		begin
			tx_ready <= stall ? ~tx_ready : 1'b1;
			if (rx_valid)
			begin
				cnt <= 0;
				last_at <= -1;
			end
			else if (tx_valid && tx_ready && cnt < 14)
			begin
				resp[cnt] <= tx_data;
				cnt <= cnt + 1;
				if (tx_last)
					last_at <= cnt;
			end
		end
endmodule

// file: cmhc_tb.sv
/*
 * Self-checking bench for the header codec with a host partner.
 * Assumes LISTEN_PORT at its default port, except in one port scenario.
 */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0, rst_b = 1'b0, tbl = 1'b1, stall = 1'b0;
	logic tx_ready, rx_valid, rx_last, tx_valid, tx_last, cmd_ok, drop;
	logic [15:0] rx_port, cmd_code;
	logic [15:0] listen_port = 16'h2580;
	logic [7:0] rx_data, tx_data;
	int mismatches = 0, checks_done = 0, ok_n, drop_n;
	localparam logic [127:0] BASE = 128'h8000_0201_0010_0120_005A_0701_AA55_0000;
	always #4 ref_clk = ~ref_clk;
	cmhc_codec u_cmhc_codec (.REF_CLK(ref_clk), .RST_B(rst_b), .LISTEN_PORT(listen_port),
		.TABLE_OK(tbl), .RX_PORT(rx_port), .RX_VALID(rx_valid), .RX_DATA(rx_data),
		.RX_LAST(rx_last), .TX_READY(tx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data),
		.TX_LAST(tx_last), .CMD_OK(cmd_ok), .CMD_CODE(cmd_code), .DROP(drop));
	cmhc_host u_cmhc_host (.clk(ref_clk), .rst_b(rst_b), .stall(stall), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .rx_port(rx_port),
		.rx_valid(rx_valid),
		.rx_data(rx_data), .rx_last(rx_last));
	always @(posedge ref_clk)
		if (rx_valid)
		begin
			ok_n <= 0;
			drop_n <= 0;
		end
		else
		begin
			ok_n <= ok_n + int'(cmd_ok !== 1'b0);
			drop_n <= drop_n + int'(drop !== 1'b0);
		end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic xfer(input logic [127:0] m, input int n, input logic [15:0] p,
		input logic t, input logic [15:0] rc, input logic dr);
		logic [7:0] b [12];
		logic [7:0] e [14];
		int k;
		for (int i = 0; i < 12; i++)
			b[i] = m[127-8*i -: 8];
		e = '{b[0] | cmhc_pkg::INFO_RESP_BIT, 8'h00, 8'h02, b[6], b[7], b[8], b[3], b[4],
			b[5], b[9], b[10], b[11], rc[15:8], rc[7:0]};
		@(posedge ref_clk);
		tbl <= t;
		u_cmhc_host.send(m, n, p);
		for (k = 0; k < 80 && (dr ? drop_n == 0 : u_cmhc_host.cnt < 14); k++)
			@(negedge ref_clk);
		if (k == 80)
		begin
			mismatches++;
			complete_run();
		end
		chk("drop", 16'(dr), 16'(drop_n));
		chk("cmd_ok", 16'(!dr && rc == 16'h0000), 16'(ok_n));
		for (int i = 0; i < 14 && !dr; i++)
			chk($sformatf("byte%0d", i), 16'(e[i]), 16'(u_cmhc_host.resp[i]));
		if (dr)
			chk("resp_count", 16'h0000, 16'(u_cmhc_host.cnt));
		else
			chk("last_at", 16'h000D, 16'(u_cmhc_host.last_at));
		if (!dr && rc == 16'h0000)
			chk("cmd_code", {b[10], b[11]}, cmd_code);
	endtask
	task automatic sc_text_stall();
		stall <= 1'b1;
		xfer(BASE, 14, 16'h2580, 1'b1, 16'h0000, 1'b0);
		stall <= 1'b0;
	endtask
	task automatic sc_edges();
		xfer(128'h8000_027F_7FFE_7F7F_1FFF_0501_0000_0000, 12, 16'h2580, 1'b1, 16'h0000,
			1'b0);
	endtask
	task automatic sc_bad_addr();
		int idx [7] = '{3, 3, 4, 5, 6, 7, 8};
		logic [7:0] v [7] = '{8'h00, 8'h80, 8'h80, 8'h20, 8'h00, 8'h80, 8'h0F};
		logic [127:0] m;
		for (int i = 0; i < 7; i++)
		begin
			m = BASE;
			m[127-8*idx[i] -: 8] = v[i];
			xfer(m, 12, 16'h2580, 1'b1, 16'h1000, 1'b0);
		end
	endtask
	task automatic sc_table();
		xfer(BASE, 12, 16'h2580, 1'b0, 16'h0500, 1'b0);
	endtask
	task automatic sc_drops();
		xfer(BASE, 11, 16'h2580, 1'b1, 16'h0000, 1'b1);
		xfer(BASE, 12, 16'h2581, 1'b1, 16'h0000, 1'b1);
		@(posedge ref_clk);
		listen_port <= 16'h3039;
		xfer(BASE, 12, 16'h3039, 1'b1, 16'h0000, 1'b0);
		xfer(BASE, 12, 16'h2580, 1'b1, 16'h0000, 1'b1);
		@(posedge ref_clk);
		listen_port <= 16'h2580;
	endtask
	initial
	begin
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
		chk("idle_valid", 16'h0000, 16'(tx_valid));
		sc_text_stall();
		sc_edges();
		sc_bad_addr();
		sc_table();
		sc_drops();
		complete_run();
	end
endmodule
